// file: src/wtp_pkg.sv
// wtp_pkg: constants and types shared by the waypoint trace port
// assumes: single core clock domain, no software-visible registers
package wtp_pkg;

    // ------------------------------------------------------------
    // field widths and buffer depth
    // ------------------------------------------------------------
    localparam int unsigned WTP_CTX_W    = 32;
    localparam int unsigned WTP_COMMIT_W = 2;
    localparam int unsigned WTP_KIND_W   = 3;
    localparam int unsigned WTP_EXC_W    = 4;
    localparam int unsigned WTP_FIFO_DEPTH = 32;

    // ------------------------------------------------------------
    // reset values and commit count limit
    // ------------------------------------------------------------
    localparam logic [31:0] WTP_CTX_RST    = 32'h0000_0000;
    localparam logic [1:0]  WTP_COMMIT_RST = 2'h0;
    localparam logic [1:0]  WTP_COMMIT_MAX = 2'h3;

    // ------------------------------------------------------------
    // waypoint kinds
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        WTP_KIND_DIRECT   = 3'h0,
        WTP_KIND_INDIRECT = 3'h1,
        WTP_KIND_EXCEPT   = 3'h2,
        WTP_KIND_BARRIER  = 3'h3,
        WTP_KIND_DBG_IN   = 3'h4,
        WTP_KIND_DBG_OUT  = 3'h5
    } wtp_kind_t;

    // ------------------------------------------------------------
    // exception kinds
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        WTP_EXC_NONE     = 4'h0,
        WTP_EXC_HALT_DBG = 4'h1,
        WTP_EXC_SEC_MON  = 4'h2,
        WTP_EXC_IMP_DABT = 4'h4,
        WTP_EXC_ENV_TRAP = 4'h5,
        WTP_EXC_UNDEFINED_INSTRUCTION_IN = 4'h9,
        WTP_EXC_SUP_CALL = 4'ha,
        WTP_EXC_PABT_BKP = 4'hb,
        WTP_EXC_DABT_WPT = 4'hc,
        WTP_EXC_NORM_IRQ = 4'he,
        WTP_EXC_FAST_IRQ = 4'hf
    } wtp_exc_t;

    // ------------------------------------------------------------
    // output state machine
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        WTP_ST_OFF  = 3'b001,
        WTP_ST_RUN  = 3'b010,
        WTP_ST_DUMP = 3'b100
    } wtp_state_t;

endpackage : wtp_pkg

// file: src/wtp_trace_port.sv
// wtp_trace_port: waypoint trace output port toward the trace macrocell
// assumes: core logic presents waypoints on a valid/ready stream, commits and
// flushes as one-cycle pulses, all on MCLK; the macrocell is on MCLK too
//
// Behaviour
// - whole port stays off, every output at its reset value, unless the trace option parameter is set.
// - every port signal is produced and sampled on the core clock.
// - two-bit commit count each cycle of waypoints turning non-speculative.
// - a waypoint may be valid and committed in the same cycle.
// - 32-bit context tag accompanies every waypoint, regardless of condition pass.
// - context tag reads zero until software programs the context identifier.
// - exception kinds use the fixed four-bit encodings.
// - link update flag only for link-writing direct or indirect branches.
// - waypoint valid confirms the waypoint fields shown that cycle.

// ----------------------------------------------------------------
// fifo
// ----------------------------------------------------------------
module wtp_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    // pointers wrap by overflow, so DEPTH must be a power of two; the
    // count is one bit wider so that full and empty differ

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      count_ff;
    logic             ready_ff;    // room for one more word after this edge
    wire  [AW:0]      nxt_count;
    wire              do_wr;
    wire              do_rd;

    // handshake decode; ready comes from a flop so the port output is registered
    // a word offered in a flush cycle is taken and dropped with the rest, since
    // everything still buffered at that point is speculative anyway
    assign in_ready  = ready_ff;
    assign out_valid = (count_ff != '0);
    assign out_data  = mem[rd_ptr_ff];
    assign do_wr     = in_valid && ready_ff && !flush;
    assign do_rd     = out_valid && out_ready;

    // fill level after this edge; a flush empties the buffer
    assign nxt_count = flush ? '0 : (AW+1)'(count_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd));

    // storage write
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    // pointers and fill count; flush empties the buffer
    // ready looks one edge ahead so that it can come straight from a flop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
            ready_ff  <= 1'b1;
        end else if (flush) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
            ready_ff  <= 1'b1;
        end else begin
            wr_ptr_ff <= do_wr ? AW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
            rd_ptr_ff <= do_rd ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
            count_ff  <= nxt_count;
            ready_ff  <= (nxt_count != (AW+1)'(DEPTH));
        end
    end
endmodule : wtp_fifo

// ----------------------------------------------------------------
// top
// ----------------------------------------------------------------
module wtp_trace_port
    import wtp_pkg::*;
#(
    parameter bit          TRACE_PRESENT = 1'b1,
    parameter int unsigned FIFO_DEPTH    = wtp_pkg::WTP_FIFO_DEPTH
) (
    input  wire logic                             MCLK,
    input  wire logic                             RST,
    // core side: waypoint stream
    input  wire logic                             CORE_WP_VALID,
    output logic                                  CORE_WP_READY,
    input  wire logic [wtp_pkg::WTP_KIND_W-1:0]   CORE_WP_KIND,
    input  wire logic [wtp_pkg::WTP_EXC_W-1:0]    CORE_WP_EXC,
    input  wire logic                             CORE_WP_LINK,
    // core side: context identifier
    input  wire logic                             CORE_CTX_WR,
    input  wire logic [wtp_pkg::WTP_CTX_W-1:0]    CORE_CTX_DATA,
    // core side: speculation outcome
    input  wire logic                             CORE_COMMIT,
    input  wire logic                             CORE_FLUSH,
    // macrocell side
    input  wire logic                             WAYPOINT_ACCEPT_EN,
    output logic                                  WAYPOINT_VALID,
    output logic [wtp_pkg::WTP_KIND_W-1:0]        WAYPOINT_KIND,
    output logic [wtp_pkg::WTP_EXC_W-1:0]         EXC_KIND,
    output logic                                  LINK_UPDATE_FLAG,
    output logic [wtp_pkg::WTP_CTX_W-1:0]         CONTEXT_TAG,
    output logic [wtp_pkg::WTP_COMMIT_W-1:0]      COMMIT_COUNT,
    output logic                                  SPECULATIVE_DISCARD
);
    import wtp_pkg::*;

    localparam int unsigned FW = WTP_KIND_W + WTP_EXC_W + 1 + WTP_CTX_W;

    // limitations: the core offers at most one commit per cycle, so the
    // carry path only matters if that input is ever widened; the enable is
    // taken as a same-clock level and is not synchronised

    // ------------------------------------------------------------
    // state and datapath
    // ------------------------------------------------------------
    wtp_state_t          state_ff;
    wtp_state_t          nxt_state;
    logic [WTP_CTX_W-1:0] ctx_ff;
    logic [1:0]          pend_ff;     // commits awaiting report
    logic [2:0]          pend_sum;
    wire                 en_sync;
    wire                 on;
    wire                 fifo_valid;
    wire                 fifo_ready;
    wire [FW-1:0]        fifo_in;
    wire [FW-1:0]        fifo_out;
    wire [WTP_KIND_W-1:0] f_kind;
    wire [WTP_EXC_W-1:0]  f_exc;
    wire                 f_link;
    wire [WTP_CTX_W-1:0] f_ctx;
    wire                 is_branch;
    wire                 is_except;
    wire                 emit;
    wire                 take_commit;
    wire                 do_flush;

    // next values of the port outputs
    wire                 present;     // waypoint popped this cycle and shown on the port the next
    wire                 commit_over; // more commits than the field can show
    wire [1:0]           nxt_pend;
    wire                 nxt_wp_valid;
    wire [WTP_KIND_W-1:0] nxt_wp_kind;
    wire [WTP_EXC_W-1:0]  nxt_exc_kind;
    wire                 nxt_link_flag;
    wire [WTP_CTX_W-1:0] nxt_ctx_tag;
    wire [1:0]           nxt_commit;
    wire                 nxt_discard;

    // ------------------------------------------------------------
    // enable and presence
    // ------------------------------------------------------------
    // accept enable comes from logic on MCLK, no synchroniser needed
    // with the trace option absent the port never leaves the off state,
    // so every output stays at its reset value
    assign en_sync = WAYPOINT_ACCEPT_EN;
    assign on      = TRACE_PRESENT && en_sync;

    // ------------------------------------------------------------
    // buffered fields
    // ------------------------------------------------------------
    // capture fields with the context current when the waypoint entered
    // the context is sampled on entry, so a later context write cannot
    // relabel waypoints already waiting in the buffer
    assign fifo_in  = {CORE_WP_KIND, CORE_WP_EXC, CORE_WP_LINK, ctx_ff};
    assign f_kind   = fifo_out[FW-1 -: WTP_KIND_W];
    assign f_exc    = fifo_out[WTP_CTX_W+1 +: WTP_EXC_W];
    assign f_link   = fifo_out[WTP_CTX_W];
    assign f_ctx    = fifo_out[WTP_CTX_W-1:0];

    // ------------------------------------------------------------
    // field qualification
    // ------------------------------------------------------------
    // only branch kinds may carry the link flag; only the exception kind
    // carries an exception code, every other kind shows zero
    assign is_branch = (f_kind == WTP_KIND_DIRECT) || (f_kind == WTP_KIND_INDIRECT);
    assign is_except = (f_kind == WTP_KIND_EXCEPT);
    assign emit      = fifo_valid && (state_ff == WTP_ST_RUN);
    assign fifo_ready = (state_ff == WTP_ST_RUN);
    assign do_flush  = CORE_FLUSH && TRACE_PRESENT;

    // ------------------------------------------------------------
    // commit accounting
    // ------------------------------------------------------------
    // commits are reported up to three per cycle; excess carries forward
    // a flush wins over a commit in the same cycle: nothing is left to commit
    assign take_commit = CORE_COMMIT && on;
    assign pend_sum    = {1'b0, pend_ff} + {2'b00, take_commit};
    assign commit_over = (pend_sum > {1'b0, WTP_COMMIT_MAX});

    // carried commits and the count shown on the port
    assign nxt_pend   = do_flush ? WTP_COMMIT_RST : (commit_over ? 2'h1 : WTP_COMMIT_RST);
    assign nxt_commit = do_flush ? WTP_COMMIT_RST :
                        (commit_over ? WTP_COMMIT_MAX : pend_sum[1:0]);

    // ------------------------------------------------------------
    // state sequencing
    // ------------------------------------------------------------
    // state sequencing: off when disabled, one dump cycle on flush
    // the dump cycle holds the buffer output back while the macrocell
    // throws away what it holds
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            WTP_ST_OFF:  nxt_state = on ? WTP_ST_RUN : WTP_ST_OFF;
            WTP_ST_RUN:  nxt_state = do_flush ? WTP_ST_DUMP : (on ? WTP_ST_RUN : WTP_ST_OFF);
            WTP_ST_DUMP: nxt_state = on ? WTP_ST_RUN : WTP_ST_OFF;
            default:     nxt_state = WTP_ST_OFF;
        endcase
    end

    // ------------------------------------------------------------
    // buffer
    // ------------------------------------------------------------
    // buffer between core and port
    // cleared by a flush and parked while the port is off
    wtp_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (MCLK),
        .rst       (RST),
        .flush     (do_flush),
        .in_valid  (CORE_WP_VALID && on),
        .in_ready  (CORE_WP_READY),
        .in_data   (fifo_in),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready),
        .out_data  (fifo_out)
    );

    // ------------------------------------------------------------
    // state and context registers
    // ------------------------------------------------------------
    // state and context tag; zero until first programming
    // the context register loads whenever the core writes it, even while
    // the port is off, so the first waypoint after enable is labelled right
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state_ff <= WTP_ST_OFF;
            ctx_ff   <= WTP_CTX_RST;
            pend_ff  <= WTP_COMMIT_RST;
        end else begin
            state_ff <= nxt_state;
            if (CORE_CTX_WR) begin
                ctx_ff <= CORE_CTX_DATA;
            end
            pend_ff <= nxt_pend;
        end
    end

    // ------------------------------------------------------------
    // port outputs
    // ------------------------------------------------------------
    // next values; a waypoint popped in a flush cycle is not shown at all
    // kind and context hold their last shown value so a macrocell that
    // samples them late still sees the waypoint it was told about
    assign present       = emit && !do_flush;
    assign nxt_wp_valid  = present;
    assign nxt_wp_kind   = present ? f_kind : WAYPOINT_KIND;
    assign nxt_exc_kind  = (present && is_except) ? f_exc : WTP_EXC_NONE;
    assign nxt_link_flag = present && is_branch && f_link;
    assign nxt_ctx_tag   = present ? f_ctx : CONTEXT_TAG;
    assign nxt_discard   = do_flush;

    // registered port outputs
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            WAYPOINT_VALID      <= 1'b0;
            WAYPOINT_KIND       <= WTP_KIND_DIRECT;
            EXC_KIND            <= WTP_EXC_NONE;
            LINK_UPDATE_FLAG    <= 1'b0;
            CONTEXT_TAG         <= WTP_CTX_RST;
            COMMIT_COUNT        <= WTP_COMMIT_RST;
            SPECULATIVE_DISCARD <= 1'b0;
        end else begin
            WAYPOINT_VALID      <= nxt_wp_valid;
            WAYPOINT_KIND       <= nxt_wp_kind;
            EXC_KIND            <= nxt_exc_kind;
            LINK_UPDATE_FLAG    <= nxt_link_flag;
            CONTEXT_TAG         <= nxt_ctx_tag;
            COMMIT_COUNT        <= nxt_commit;
            SPECULATIVE_DISCARD <= nxt_discard;
        end
    end
endmodule : wtp_trace_port

// file: test/wtp_trace_port_monitor.sv
// wtp_trace_port_monitor: timing checks on the waypoint trace port
// assumes: bound into wtp_trace_port, one clock MCLK, async RST
module wtp_trace_port_monitor (
    input wire logic        MCLK,
    input wire logic        RST,
    input wire logic        CORE_WP_VALID,
    input wire logic        CORE_WP_READY,
    input wire logic        CORE_CTX_WR,
    input wire logic        CORE_COMMIT,
    input wire logic        CORE_FLUSH,
    input wire logic        WAYPOINT_ACCEPT_EN,
    input wire logic        WAYPOINT_VALID,
    input wire logic [2:0]  WAYPOINT_KIND,
    input wire logic [3:0]  EXC_KIND,
    input wire logic        LINK_UPDATE_FLAG,
    input wire logic [31:0] CONTEXT_TAG,
    input wire logic [1:0]  COMMIT_COUNT,
    input wire logic        SPECULATIVE_DISCARD
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ctx_seen_ff;
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    // remembers whether a context was ever loaded
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) ctx_seen_ff <= 1'b0;
        else if (CORE_CTX_WR) ctx_seen_ff <= 1'b1;
    end
    property p_link; LINK_UPDATE_FLAG |-> WAYPOINT_VALID && WAYPOINT_KIND <= 3'h1; endproperty
    a_link: assert property (p_link) else $error("link flag outside a branch");
    property p_cnt; CORE_COMMIT && WAYPOINT_ACCEPT_EN && !CORE_FLUSH |=> COMMIT_COUNT == 2'h1; endproperty
    a_cnt: assert property (p_cnt) else $error("commit not counted");
    property p_cnt0; !CORE_COMMIT |=> COMMIT_COUNT == 2'h0; endproperty
    a_cnt0: assert property (p_cnt0) else $error("commit count without commit");
    property p_dsc; CORE_FLUSH |=> SPECULATIVE_DISCARD; endproperty
    a_dsc: assert property (p_dsc) else $error("flush not signalled");
    property p_dsc0; !CORE_FLUSH |=> !SPECULATIVE_DISCARD; endproperty
    a_dsc0: assert property (p_dsc0) else $error("discard without flush");
    property p_dump; SPECULATIVE_DISCARD |-> !WAYPOINT_VALID ##1 !WAYPOINT_VALID; endproperty
    a_dump: assert property (p_dump) else $error("waypoint during discard");
    property p_exc; !(WAYPOINT_VALID && WAYPOINT_KIND == 3'h2) |-> EXC_KIND == 4'h0; endproperty
    a_exc: assert property (p_exc) else $error("exception code outside exception");
    property p_ctx; !ctx_seen_ff |-> CONTEXT_TAG == 32'h0; endproperty
    a_ctx: assert property (p_ctx) else $error("context tag before load");
    property p_lat; CORE_WP_VALID && CORE_WP_READY && WAYPOINT_ACCEPT_EN ##1 !CORE_FLUSH [*2]
        |-> ##[0:40] WAYPOINT_VALID; endproperty
    a_lat: assert property (p_lat) else $error("waypoint never presented");
endmodule : wtp_trace_port_monitor

bind wtp_trace_port wtp_trace_port_monitor wtp_trace_port_monitor_i (.MCLK, .RST, .CORE_WP_VALID,
    .CORE_WP_READY, .CORE_CTX_WR, .CORE_COMMIT, .CORE_FLUSH, .WAYPOINT_ACCEPT_EN, .WAYPOINT_VALID,
    .WAYPOINT_KIND, .EXC_KIND, .LINK_UPDATE_FLAG, .CONTEXT_TAG, .COMMIT_COUNT, .SPECULATIVE_DISCARD);

// file: test/wtp_macro_model.sv
// wtp_macro_model: trace macrocell standing at the far side of the port
// assumes: same clock as the core, enable asked for by the bench
module wtp_macro_model (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       en_req,
    input wire logic       wp_valid,
    input wire logic [1:0] commit_cnt,
    input wire logic       discard,
    output logic           accept_en,
    output logic [7:0]     held_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] nxt_held;
    // the macrocell alone drives the enable
    assign accept_en = en_req;
    assign nxt_held  = held_ff + 8'(wp_valid);
    // speculative waypoints held until committed, dropped on discard
    always_ff @(posedge clk or posedge rst) begin
        if (rst) held_ff <= 8'h0;
        else if (discard) held_ff <= 8'h0;
        else held_ff <= (nxt_held > 8'(commit_cnt)) ? nxt_held - 8'(commit_cnt) : 8'h0;
    end
endmodule : wtp_macro_model

// file: test/wtp_trace_port_test.sv
// wtp_trace_port_test: self-checking bench for the waypoint trace port
// assumes: wtp_macro_model as far side, inputs driven at falling edge
module wtp_trace_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    import wtp_pkg::*;
    logic MCLK = 1'b0, RST = 1'b1, CORE_WP_VALID = 1'b0, CORE_WP_LINK = 1'b0, CORE_CTX_WR = 1'b0;
    logic CORE_COMMIT = 1'b0, CORE_FLUSH = 1'b0, en_req = 1'b1;
    logic [2:0] CORE_WP_KIND = 3'h0;
    logic [3:0] CORE_WP_EXC = 4'h0;
    logic [31:0] CORE_CTX_DATA = 32'h0, ctx_m = 32'h0, CONTEXT_TAG;
    logic CORE_WP_READY, WAYPOINT_ACCEPT_EN, WAYPOINT_VALID, LINK_UPDATE_FLAG, SPECULATIVE_DISCARD;
    logic [2:0] WAYPOINT_KIND;
    logic [3:0] EXC_KIND;
    logic [1:0] COMMIT_COUNT;
    logic [7:0] held;
    logic [39:0] exp_q[$];
    logic [3:0] codes[10] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h9, 4'ha, 4'hb, 4'hc, 4'he, 4'hf};
    int num_errors = 0, comparisons = 0, cycles = 0;
    wtp_trace_port wtp_trace_port_i (.MCLK, .RST, .CORE_WP_VALID, .CORE_WP_READY, .CORE_WP_KIND, .CORE_WP_EXC,
        .CORE_WP_LINK, .CORE_CTX_WR, .CORE_CTX_DATA, .CORE_COMMIT, .CORE_FLUSH, .WAYPOINT_ACCEPT_EN,
        .WAYPOINT_VALID, .WAYPOINT_KIND, .EXC_KIND, .LINK_UPDATE_FLAG, .CONTEXT_TAG, .COMMIT_COUNT,
        .SPECULATIVE_DISCARD);
    wtp_macro_model wtp_macro_model_i (.clk(MCLK), .rst(RST), .en_req, .wp_valid(WAYPOINT_VALID),
        .commit_cnt(COMMIT_COUNT), .discard(SPECULATIVE_DISCARD), .accept_en(WAYPOINT_ACCEPT_EN), .held_ff(held));
    // clock and hang guard
    initial forever #10 MCLK = ~MCLK;
    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            stop_test();
        end
    end
    task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // every presented waypoint must match the oldest one offered
    always @(negedge MCLK) begin
        if (WAYPOINT_VALID === 1'b1) begin
            if (exp_q.size() == 0) chk("unexpected waypoint", 40'h0, 40'h1);
            else chk("waypoint", exp_q.pop_front(), {WAYPOINT_KIND, EXC_KIND, LINK_UPDATE_FLAG, CONTEXT_TAG});
        end
    end
    task automatic send(input logic [2:0] k, input logic [3:0] e, input logic l, input logic c);
        @(negedge MCLK);
        CORE_WP_VALID = 1'b1;
        CORE_WP_KIND = k;
        CORE_WP_EXC = e;
        CORE_WP_LINK = l;
        CORE_COMMIT = c;
        while (CORE_WP_READY !== 1'b1) @(negedge MCLK);
        @(posedge MCLK);
        if (en_req) exp_q.push_back({k, (k == 3'h2) ? e : 4'h0, l && (k <= 3'h1), ctx_m});
    endtask : send
    task automatic end_test(input string name);
        @(negedge MCLK);
        CORE_WP_VALID = 1'b0;
        CORE_COMMIT = 1'b0;
        repeat (6) @(negedge MCLK);
        chk("missing waypoints", 40'h0, 40'(exp_q.size()));
        $display("test %s done", name);
    endtask : end_test
    task automatic t_stream();
        for (int i = 0; i < 10; i++) send(3'h2, codes[i], 1'b1, 1'b0);
        for (int i = 0; i < 32; i++) send(3'(i % 6), 4'h7, i[0], 1'b0);
        end_test("stream");
    endtask : t_stream
    task automatic t_ctx();
        @(negedge MCLK);
        CORE_CTX_WR = 1'b1;
        CORE_CTX_DATA = 32'h5a5a_1234;
        ctx_m = 32'h5a5a_1234;
        @(negedge MCLK);
        CORE_CTX_WR = 1'b0;
        send(3'h0, 4'h0, 1'b0, 1'b0);
        end_test("context");
    endtask : t_ctx
    task automatic t_commit();
        send(3'h1, 4'h0, 1'b1, 1'b1);
        @(negedge MCLK);
        CORE_WP_VALID = 1'b0;
        chk("commit count", 40'h1, 40'(COMMIT_COUNT));
        @(negedge MCLK);
        CORE_COMMIT = 1'b0;
        chk("commit with valid", 40'h5, {37'h0, WAYPOINT_VALID, COMMIT_COUNT});
        end_test("commit");
    endtask : t_commit
    task automatic t_flush();
        send(3'h3, 4'h0, 1'b0, 1'b0);
        @(negedge MCLK);
        CORE_WP_VALID = 1'b0;
        CORE_FLUSH = 1'b1;
        @(negedge MCLK);
        CORE_FLUSH = 1'b0;
        exp_q.delete();
        chk("discard", 40'h1, 40'(SPECULATIVE_DISCARD));
        @(negedge MCLK);
        chk("held after discard", 40'h0, 40'(held));
        end_test("flush");
    endtask : t_flush
    task automatic t_enable();
        en_req = 1'b0;
        send(3'h1, 4'h0, 1'b0, 1'b0);
        end_test("enable off");
        en_req = 1'b1;
    endtask : t_enable
    task automatic stop_test();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : stop_test
    initial begin
        repeat (12) @(negedge MCLK);
        RST = 1'b0;
        chk("ready after reset", 40'h1, 40'(CORE_WP_READY));
        chk("tag after reset", 40'h0, 40'(CONTEXT_TAG));
        t_stream();
        t_ctx();
        t_commit();
        t_flush();
        t_enable();
        stop_test();
    end
endmodule : wtp_trace_port_test
